// >>> cab_pkg.sv
`default_nettype none
package cab_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PC_W   = 21;
  localparam int unsigned BANK_W = 4;

  // Opcode fields
  localparam logic [7:0] JUMP_OPC    = 8'hEF;
  localparam logic [3:0] JUMP_W2_PFX = 4'hF;
  localparam logic [5:0] INC_OPC     = 6'h0A;
  localparam logic [5:0] RRNC_OPC    = 6'h10;
  localparam logic [6:0] ONES_OPC    = 7'h34;
  localparam logic [7:0] LSUB_OPC    = 8'h08;
  localparam logic [5:0] FSUB_OPC    = 6'h17;

  // Field positions
  localparam int unsigned DEST_BIT = 9;
  localparam int unsigned ACC_BIT  = 8;

  // Access bank split and indexed window
  localparam logic [7:0] ILO_MAX   = 8'h5F;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] SFR_PAGE  = 4'hF;
  localparam logic [3:0] LOW_PAGE  = 4'h0;

  // Reset values and fixed data
  localparam logic [7:0]  WREG_RST   = 8'h00;
  localparam logic [4:0]  STATUS_RST = 5'h00;
  localparam logic [20:0] PC_RST     = 21'h0_0000;
  localparam logic [7:0]  ONES       = 8'hFF;
  localparam logic [7:0]  ONE        = 8'h01;
  localparam logic [4:0]  FLAGS_ALL  = 5'h1F;
  localparam logic [4:0]  FLAGS_NZ   = 5'h14;
  localparam logic [4:0]  FLAGS_NONE = 5'h00;

  typedef enum logic [3:0] {
    Q1 = 4'h1,
    Q2 = 4'h2,
    Q3 = 4'h4,
    Q4 = 4'h8
  } cab_qtr_e;

  typedef enum logic [6:0] {
    OP_NONE  = 7'h01,
    OP_JUMP  = 7'h02,
    OP_INC   = 7'h04,
    OP_RRNC  = 7'h08,
    OP_ONES  = 7'h10,
    OP_LSUB  = 7'h20,
    OP_FSUB  = 7'h40
  } cab_op_e;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } cab_flags_s;

  typedef struct packed {
    logic [7:0] value;
    cab_flags_s flags;
    cab_flags_s upd;
  } cab_alu_s;

  function automatic cab_op_e cab_decode(input logic [15:0] w);
    cab_op_e op;
    op = OP_NONE;
    if (w[15:8] == JUMP_OPC) op = OP_JUMP;
    else if (w[15:10] == INC_OPC) op = OP_INC;
    else if (w[15:10] == RRNC_OPC) op = OP_RRNC;
    else if (w[15:9] == ONES_OPC) op = OP_ONES;
    else if (w[15:8] == LSUB_OPC) op = OP_LSUB;
    else if (w[15:10] == FSUB_OPC) op = OP_FSUB;
    return op;
  endfunction

  function automatic logic cab_is_file_op(input cab_op_e op);
    return (op == OP_INC) || (op == OP_RRNC) || (op == OP_ONES) ||
           (op == OP_FSUB);
  endfunction

endpackage
`default_nettype wire

// >>> cab_alu.sv
`timescale 1ns/10ps
`default_nettype none
module cab_alu
  import cab_pkg::*;
(
  input  wire cab_op_e    op,
  input  wire logic [7:0] operand,
  input  wire logic [7:0] wreg,
  input  wire logic [7:0] literal,
  output cab_alu_s        res
);

  // Add with carry in; subtraction passes the inverted subtrahend
  function automatic cab_alu_s add8(input logic [7:0] a,
                                    input logic [7:0] b,
                                    input logic       cin);
    cab_alu_s   r;
    logic [8:0] sum;
    logic [4:0] low;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    r.value    = sum[7:0];
    r.flags.c  = sum[8];
    r.flags.dc = low[4];
    r.flags.n  = sum[7];
    r.flags.z  = (sum[7:0] == 8'h00);
    r.flags.ov = (a[7] == b[7]) && (sum[7] != a[7]);
    r.upd      = FLAGS_ALL;
    return r;
  endfunction

  always_comb begin
    res = '0;
    case (op)
      OP_INC:   res = add8(operand, ONE, 1'b0);
      OP_FSUB:  res = add8(operand, ~wreg, 1'b1);
      OP_LSUB:  res = add8(literal, ~wreg, 1'b1);
      OP_RRNC: begin
        res.value   = {operand[0], operand[7:1]};
        res.flags.n = operand[0];
        res.flags.z = (operand == 8'h00);
        res.upd     = FLAGS_NZ;
      end
      OP_ONES: begin
        res.value = ONES;
        res.upd   = FLAGS_NONE;
      end
      default: res = '0;
    endcase
  end

endmodule // cab_alu
`default_nettype wire

// >>> cab_addr_map.sv
`timescale 1ns/10ps
`default_nettype none
module cab_addr_map
  import cab_pkg::*;
(
  input  wire logic [7:0]  file_addr,
  input  wire logic        access_sel,
  input  wire logic [3:0]  bank_select_reg,
  input  wire logic        ext_inst_en,
  input  wire logic [11:0] index_base,
  output logic [11:0]      phys_addr
);

  always_comb begin
    if (access_sel) begin
      phys_addr = {bank_select_reg, file_addr};
    end else if (ext_inst_en && (file_addr <= ILO_MAX)) begin
      phys_addr = index_base + {4'h0, file_addr};
    end else if (file_addr < ACC_SPLIT) begin
      phys_addr = {LOW_PAGE, file_addr};
    end else begin
      phys_addr = {SFR_PAGE, file_addr};
    end
  end

endmodule // cab_addr_map
`default_nettype wire

// >>> cab_top.sv
// Functional notes
// - Jump loads 20-bit literal into PC bits 20:1
// - Jump is two words, two cycles
// - Jump: low literal Q2, high and PC Q4
// - Destination bit: 0 accumulator, 1 file register
// - Access bit 0 quick bank, 1 bank select
// - Extended set, address up to 95: indexed offset
// - Increment register, update C DC N OV Z
// - Rotate right without carry, only N Z
// - Literal minus accumulator into accumulator
// - Register minus accumulator to chosen destination
// - Subtract carry set means no borrow
`timescale 1ns/10ps
`default_nettype none
module cab_top
  import cab_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic        ext_inst_en,
  input  wire logic [3:0]  bank_select_reg,
  input  wire logic [11:0] index_base,
  input  wire logic [7:0]  rf_rdata,
  output cab_qtr_e         quarter,
  output logic [11:0]      rf_addr,
  output logic             rf_rd,
  output logic             rf_wr,
  output logic [7:0]       rf_wdata,
  output logic [7:0]       wreg,
  output cab_flags_s       status,
  output logic [20:0]      pc,
  output logic             pc_load,
  output logic             nop_cycle
);

  cab_op_e    op;
  logic [15:0] ir;
  logic [7:0]  lit_lo;
  logic [7:0]  operand;
  cab_alu_s    result;

  cab_qtr_e    next_quarter;
  cab_op_e     next_op;
  logic [15:0] next_ir;
  logic [7:0]  next_lit_lo;
  logic [7:0]  next_operand;
  cab_alu_s    next_result;
  logic [11:0] next_rf_addr;
  logic        next_rf_rd;
  logic        next_rf_wr;
  logic [7:0]  next_rf_wdata;
  logic [7:0]  next_wreg;
  cab_flags_s  next_status;
  logic [20:0] next_pc;
  logic        next_pc_load;
  logic        next_nop_cycle;

  cab_alu_s    alu_res;
  logic [11:0] map_addr;
  cab_op_e     dec_op;
  logic        w2_ok;
  logic        to_file;

  assign dec_op  = cab_decode(instr_word);
  assign w2_ok   = instr_valid && (instr_word[15:12] == JUMP_W2_PFX);
  assign to_file = (op == OP_ONES) ||
                   (cab_is_file_op(op) && ir[DEST_BIT]);

  cab_addr_map u_addr_map (
    .file_addr       (instr_word[7:0]),
    .access_sel      (instr_word[ACC_BIT]),
    .bank_select_reg (bank_select_reg),
    .ext_inst_en     (ext_inst_en),
    .index_base      (index_base),
    .phys_addr       (map_addr)
  );

  cab_alu u_alu (
    .op      (op),
    .operand (operand),
    .wreg    (wreg),
    .literal (ir[7:0]),
    .res     (alu_res)
  );

  always_comb begin
    next_quarter   = quarter;
    next_op        = op;
    next_ir        = ir;
    next_lit_lo    = lit_lo;
    next_operand   = operand;
    next_result    = result;
    next_rf_addr   = rf_addr;
    next_rf_rd     = 1'b0;
    next_rf_wr     = 1'b0;
    next_rf_wdata  = rf_wdata;
    next_wreg      = wreg;
    next_status    = status;
    next_pc        = pc;
    next_pc_load   = 1'b0;
    next_nop_cycle = nop_cycle;
    case (quarter)
      Q1: begin
        next_quarter = Q2;
        next_op      = OP_NONE;
        // Decode; the cycle after a jump does nothing
        if (!nop_cycle && instr_valid) begin
          next_ir = instr_word;
          next_op = dec_op;
          if (cab_is_file_op(dec_op)) begin
            next_rf_rd   = 1'b1;
            next_rf_addr = map_addr;
          end
        end
      end
      Q2: begin
        next_quarter = Q3;
        if (op == OP_JUMP) begin
          next_lit_lo = ir[7:0];
        end
        if (cab_is_file_op(op)) begin
          next_operand = rf_rdata;
        end
      end
      Q3: begin
        next_quarter = Q4;
        next_result  = alu_res;
        if (to_file) begin
          next_rf_wr    = 1'b1;
          next_rf_wdata = alu_res.value;
        end
      end
      Q4: begin
        next_quarter   = Q1;
        next_nop_cycle = 1'b0;
        if (op == OP_JUMP && w2_ok) begin
          next_pc        = {instr_word[11:0], lit_lo, 1'b0};
          next_pc_load   = 1'b1;
          next_nop_cycle = 1'b1;
        end
        if ((op == OP_LSUB) ||
            ((op != OP_ONES) && cab_is_file_op(op) && !ir[DEST_BIT])) begin
          next_wreg = result.value;
        end
        // Only flags marked by the operation change
        next_status = (status & ~result.upd) |
                      (result.flags & result.upd);
      end
      default: next_quarter = Q1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      quarter   <= Q1;
      op        <= OP_NONE;
      ir        <= 16'h0000;
      lit_lo    <= 8'h00;
      operand   <= 8'h00;
      result    <= '0;
      rf_addr   <= 12'h000;
      rf_rd     <= 1'b0;
      rf_wr     <= 1'b0;
      rf_wdata  <= 8'h00;
      wreg      <= WREG_RST;
      status    <= STATUS_RST;
      pc        <= PC_RST;
      pc_load   <= 1'b0;
      nop_cycle <= 1'b0;
    end else begin
      quarter   <= next_quarter;
      op        <= next_op;
      ir        <= next_ir;
      lit_lo    <= next_lit_lo;
      operand   <= next_operand;
      result    <= next_result;
      rf_addr   <= next_rf_addr;
      rf_rd     <= next_rf_rd;
      rf_wr     <= next_rf_wr;
      rf_wdata  <= next_rf_wdata;
      wreg      <= next_wreg;
      status    <= next_status;
      pc        <= next_pc;
      pc_load   <= next_pc_load;
      nop_cycle <= next_nop_cycle;
    end
  end

  // Helper expectations for the checks below
  logic [11:0] w2_hi;
  logic [7:0]  rot_exp;
  logic [7:0]  inc_exp;
  logic [7:0]  lsub_exp;
  logic [7:0]  fsub_exp;
  logic        nob_exp;
  logic        take_file;
  assign w2_hi     = instr_word[11:0];
  assign rot_exp   = {operand[0], operand[7:1]};
  assign inc_exp   = operand + ONE;
  assign lsub_exp  = ir[7:0] - wreg;
  assign fsub_exp  = operand - wreg;
  assign nob_exp   = (operand >= wreg);
  assign take_file = (quarter == Q1) && !nop_cycle && instr_valid &&
                     cab_is_file_op(dec_op);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_jump_fire;
    quarter == Q4 && op == OP_JUMP && w2_ok;
  endsequence

  sequence s_nop_run;
    nop_cycle && !rf_rd && !rf_wr;
  endsequence

  property p_quarters;
    quarter == Q1 |=> quarter == Q2 ##1 quarter == Q3 ##1 quarter == Q4
      ##1 quarter == Q1;
  endproperty
  a_quarters: assert property (p_quarters)
    else $error("quarter sequence broken");

  property p_jump_load;
    s_jump_fire |=> pc_load && pc == {$past(w2_hi), lit_lo, 1'b0};
  endproperty
  a_jump_load: assert property (p_jump_load)
    else $error("jump target not loaded");

  property p_jump_two_cycles;
    s_jump_fire |=> s_nop_run [*4] ##1 !nop_cycle;
  endproperty
  a_jump_two_cycles: assert property (p_jump_two_cycles)
    else $error("jump second cycle not idle");

  property p_jump_low;
    quarter == Q2 && op == OP_JUMP |=> lit_lo == $past(ir[7:0]);
  endproperty
  a_jump_low: assert property (p_jump_low)
    else $error("low literal not taken in Q2");

  property p_dest_w;
    quarter == Q4 && !ir[DEST_BIT] && op != OP_ONES && cab_is_file_op(op)
      |-> !rf_wr ##1 wreg == $past(result.value);
  endproperty
  a_dest_w: assert property (p_dest_w)
    else $error("accumulator destination wrong");

  property p_dest_f;
    quarter == Q3 && to_file |=> rf_wr && rf_wdata == $past(alu_res.value);
  endproperty
  a_dest_f: assert property (p_dest_f)
    else $error("file destination not written");

  property p_bank;
    take_file && instr_word[ACC_BIT]
      |=> rf_rd && rf_addr == {$past(bank_select_reg), ir[7:0]};
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank select address wrong");

  property p_indexed;
    take_file && !instr_word[ACC_BIT] && ext_inst_en &&
      instr_word[7:0] <= ILO_MAX
      |=> rf_addr == $past(index_base) + {4'h0, ir[7:0]};
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed offset address wrong");

  property p_inc;
    quarter == Q3 && op == OP_INC
      |=> result.value == $past(inc_exp) && result.upd == FLAGS_ALL;
  endproperty
  a_inc: assert property (p_inc)
    else $error("increment result wrong");

  property p_rrnc;
    quarter == Q3 && op == OP_RRNC
      |=> result.value == $past(rot_exp) && result.upd == FLAGS_NZ;
  endproperty
  a_rrnc: assert property (p_rrnc)
    else $error("rotate result wrong");

  property p_lsub;
    quarter == Q3 && op == OP_LSUB |=> result.value == $past(lsub_exp);
  endproperty
  a_lsub: assert property (p_lsub)
    else $error("literal subtract wrong");

  property p_fsub;
    quarter == Q3 && op == OP_FSUB |=> result.value == $past(fsub_exp);
  endproperty
  a_fsub: assert property (p_fsub)
    else $error("register subtract wrong");

  property p_borrow;
    quarter == Q3 && op == OP_FSUB
      |=> result.flags.c == $past(nob_exp) &&
          result.flags.n == result.value[7];
  endproperty
  a_borrow: assert property (p_borrow)
    else $error("subtract carry wrong");

  property p_ones;
    quarter == Q3 && op == OP_ONES
      |=> rf_wr && rf_wdata == ONES ##1 $stable(status);
  endproperty
  a_ones: assert property (p_ones)
    else $error("set register wrong");

endmodule // cab_top
`default_nettype wire

// >>> cab_rf_model.sv
`timescale 1ns/10ps
`default_nettype none
module cab_rf_model (
  input  wire logic        sys_clk,
  input  wire logic [11:0] rf_addr,
  input  wire logic        rf_rd,
  input  wire logic        rf_wr,
  input  wire logic [7:0]  rf_wdata,
  output logic [7:0]       rf_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] last;

  initial begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i) ^ 8'hA5;
    last = 8'h00;
  end

  // Idle read bus toggles so stale data never passes
  assign rf_rdata = rf_rd ? mem[rf_addr] : ~last;

  always @(posedge sys_clk) begin
    last <= rf_rdata;
    if (rf_wr)
      mem[rf_addr] <= rf_wdata;
  end
endmodule // cab_rf_model
`default_nettype wire

// >>> tb_cpu_alu_branch_subset.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin \
  checked++; \
  if ((a) !== (e)) begin \
    err_total++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); \
  end \
end
module tb_cpu_alu_branch_subset
  import cab_pkg::*;
;
  typedef struct packed {
    int unsigned due;
    logic [1:0]  kind;
    logic [39:0] val;
  } cab_exp_s;

  logic        sys_clk;
  logic        rstn;
  logic        instr_valid;
  logic [15:0] instr_word;
  logic        ext_inst_en;
  logic [3:0]  bank_select_reg;
  logic [11:0] index_base;
  logic [7:0]  rf_rdata;
  cab_qtr_e    quarter;
  logic [11:0] rf_addr;
  logic        rf_rd;
  logic        rf_wr;
  logic [7:0]  rf_wdata;
  logic [7:0]  wreg;
  cab_flags_s  status;
  logic [20:0] pc;
  logic        pc_load;
  logic        nop_cycle;
  int          err_total;
  int          checked;
  int unsigned cyc;
  logic [31:0] seed;
  logic [7:0]  shadow [4096];
  logic [7:0]  wr_m;
  cab_flags_s  flg;
  logic [20:0] pcm;
  cab_exp_s    expq [$];
  cab_exp_s    e;
  bit          wr_at [int unsigned];
  bit          ld_at [int unsigned];
  bit          rd_at [int unsigned];

  wire logic [24:0] g_wr = {rf_wr, quarter, rf_addr, rf_wdata};
  wire logic [16:0] g_rd = {rf_rd, quarter, rf_addr};
  wire logic [34:0] g_st = {nop_cycle, pc, wreg, status};
  wire logic [4:0]  g_nq = {nop_cycle, quarter};

  cab_top u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr_word(instr_word), .ext_inst_en(ext_inst_en),
    .bank_select_reg(bank_select_reg), .index_base(index_base),
    .rf_rdata(rf_rdata), .quarter(quarter), .rf_addr(rf_addr),
    .rf_rd(rf_rd), .rf_wr(rf_wr), .rf_wdata(rf_wdata), .wreg(wreg),
    .status(status), .pc(pc), .pc_load(pc_load), .nop_cycle(nop_cycle)
  );

  cab_rf_model u_rf (
    .sys_clk(sys_clk), .rf_addr(rf_addr), .rf_rd(rf_rd),
    .rf_wr(rf_wr), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [11:0] addr_of(input logic [7:0] f,
                                          input logic a);
    if (a)
      return {bank_select_reg, f};
    if (ext_inst_en && f <= 8'h5F)
      return index_base + {4'h0, f};
    return {(f < 8'h60) ? 4'h0 : 4'hF, f};
  endfunction

  function automatic logic [12:0] sub8(input logic [7:0] p,
                                       input logic [7:0] q);
    logic [7:0] d;
    d = p - q;
    return {d, d[7], (p[7] ^ q[7]) & (d[7] ^ p[7]), d == 8'h00,
            p[3:0] >= q[3:0], p >= q};
  endfunction

  task automatic test_done();
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic run_op(input logic [15:0] w, input logic [15:0] w2,
                        input logic v2);
    logic [11:0] a;
    logic [7:0]  x;
    logic [7:0]  r;
    logic        fo;
    logic        dst;
    logic        tk;
    cab_flags_s  nf;
    int unsigned k;
    k = cyc;
    a = addr_of(w[7:0], w[8]);
    x = shadow[a];
    nf = flg;
    r = wr_m;
    fo = 1'b1;
    dst = w[9];
    tk = w[15:8] == 8'hEF && v2 && w2[15:12] == 4'hF;
    if (w[15:10] == 6'h0A) begin
      r = x + 8'h01;
      nf = '{r[7], x == 8'h7F, r == 8'h00, x[3:0] == 4'hF, x == 8'hFF};
    end else if (w[15:10] == 6'h10) begin
      r = {x[0], x[7:1]};
      nf.n = r[7];
      nf.z = r == 8'h00;
    end else if (w[15:9] == 7'h34) begin
      r = 8'hFF;
      dst = 1'b1;
    end else if (w[15:10] == 6'h17)
      {r, nf} = sub8(x, wr_m);
    else begin
      fo = 1'b0;
      dst = 1'b0;
      if (w[15:8] == 8'h08)
        {r, nf} = sub8(w[7:0], wr_m);
    end
    if (fo) begin
      expq.push_back('{k + 1, 2'd1, 40'({1'b1, Q2, a})});
      rd_at[k + 1] = 1'b1;
    end
    if (fo && dst) begin
      expq.push_back('{k + 3, 2'd0, 40'({1'b1, Q4, a, r})});
      wr_at[k + 3] = 1'b1;
      shadow[a] = r;
    end else
      wr_m = r;
    if (tk) begin
      pcm = {w2[11:0], w[7:0], 1'b0};
      ld_at[k + 4] = 1'b1;
    end
    flg = nf;
    expq.push_back('{k + 4, 2'd2, 40'({tk, pcm, wr_m, nf})});
    if (tk)
      expq.push_back('{k + 7, 2'd3, 40'({1'b1, Q4})});
    instr_word = w;
    instr_valid = 1'b1;
    // Valid word in Q2 must be ignored
    @(posedge sys_clk) #1;
    instr_word = 16'h2BFF;
    @(posedge sys_clk) #1;
    instr_valid = 1'b0;
    @(posedge sys_clk) #1;
    instr_word = w2;
    instr_valid = v2;
    @(posedge sys_clk) #1;
    if (tk) begin
      instr_word = 16'h2BFF;
      @(posedge sys_clk) #1;
      instr_valid = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      test_done();
    end
  end

  always @(posedge sys_clk) begin
    #2;
    `CHK(rf_wr, 1'(wr_at.exists(cyc)))
    `CHK(pc_load, 1'(ld_at.exists(cyc)))
    `CHK(rf_rd, 1'(rd_at.exists(cyc)))
    while (expq.size() > 0 && expq[0].due == cyc) begin
      e = expq.pop_front();
      case (e.kind)
        2'd0: `CHK(g_wr, e.val[24:0])
        2'd1: `CHK(g_rd, e.val[16:0])
        2'd2: `CHK(g_st, e.val[34:0])
        default: `CHK(g_nq, e.val[4:0])
      endcase
    end
  end

  initial begin
    logic [31:0] x;
    logic [15:0] w;
    logic [7:0]  f;
    rstn = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    ext_inst_en = 1'b0;
    bank_select_reg = 4'h0;
    index_base = 12'h000;
    err_total = 0;
    checked = 0;
    cyc = 0;
    seed = 32'h0000_0014;
    wr_m = 8'h00;
    flg = '0;
    pcm = 21'h0_0000;
    for (int i = 0; i < 4096; i++)
      shadow[i] = 8'(i) ^ 8'hA5;
    repeat (20) @(posedge sys_clk);
    #1;
    `CHK({g_st, quarter, rf_rd, rf_wr}, {35'h0, Q1, 2'b00})
    rstn = 1'b1;
    for (int n = 0; n < 300; n++) begin
      x = rnd();
      f = x[21] ? x[31:24] : (x[22] ? 8'h5F : 8'h60);
      ext_inst_en = x[3];
      bank_select_reg = x[7:4];
      index_base = x[19:8];
      case (x[2:0])
        3'd0: w = {6'h0A, x[9:8], f};
        3'd1: w = {6'h10, x[9:8], f};
        3'd2: w = {7'h34, x[8], f};
        3'd3: w = {8'h08, x[31:24]};
        3'd4: w = {6'h17, x[9:8], f};
        3'd5: w = {4'h7, x[27:16]};
        default: w = {8'hEF, x[31:24]};
      endcase
      run_op(w, {x[23] ? 4'hF : 4'h7, x[19:8]}, x[10]);
    end
    repeat (10) @(posedge sys_clk);
    `CHK(expq.size(), 0)
    test_done();
  end
endmodule // tb_cpu_alu_branch_subset
`default_nettype wire
